//--- logic/flags_bank_pkg.sv
package flags_bank_pkg;

	// ----------------------------------------
	// register offsets (bank 3 view)
	// ----------------------------------------
	localparam logic [8:0] OFS_INDIRECT_DATA = 9'h180;
	localparam logic [8:0] OFS_PRESCALE_CFG = 9'h181;
	localparam logic [8:0] OFS_PC_LOW = 9'h182;
	localparam logic [8:0] OFS_FLAGS = 9'h183;
	localparam logic [8:0] OFS_INDIRECT_PTR = 9'h184;
	localparam logic [8:0] OFS_PORT_B_DIR = 9'h186;
	localparam logic [8:0] OFS_PC_HIGH_HOLD = 9'h18a;
	localparam logic [8:0] OFS_INT_CONTROL = 9'h18b;
	localparam logic [8:0] OFS_NVM_CONTROL = 9'h18c;
	localparam logic [8:0] OFS_NVM_UNLOCK = 9'h18d;
	localparam logic [8:0] OFS_RSVD_A = 9'h18e;
	localparam logic [8:0] OFS_RSVD_B = 9'h18f;
	localparam logic [6:0] MIRROR_MASK = 7'h7f;

	// ----------------------------------------
	// flag register fields, prescaler assign bit and pc high width
	// ----------------------------------------
	localparam int BIT_IND_BANK = 7;
	localparam int BIT_DIR_BANK_HI = 6;
	localparam int BIT_DIR_BANK_LO = 5;
	localparam int BIT_TIMEOUT = 4;
	localparam int BIT_POWERDOWN = 3;
	localparam int BIT_ZERO = 2;
	localparam int BIT_DIGIT_CARRY = 1;
	localparam int BIT_CARRY = 0;
	localparam int BIT_PRESCALER_ASSIGN = 3;
	localparam int PC_HIGH_BITS = 5;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_FLAGS = 8'h18;
	localparam logic [7:0] RST_PRESCALE_CFG = 8'hff;
	localparam logic [7:0] RST_PORT_B_DIR = 8'hff;
	localparam logic [7:0] RST_ZERO_BYTE = 8'h00;
	localparam logic [3:0] RST_WATCHDOG_POSTSCALE = 4'h8;

	// ----------------------------------------
	// alu operations reported by the core
	// ----------------------------------------
	typedef enum logic [2:0] {
		OP_NONE,
		OP_ADD,
		OP_SUB,
		OP_LOGIC,
		OP_ROT_LEFT,
		OP_ROT_RIGHT
	} alu_op_t;

	typedef struct packed {
		logic [8:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	typedef struct packed {
		alu_op_t op;
		logic [7:0] a;
		logic [7:0] b;
	} alu_req_t;

	typedef struct packed {
		logic watchdog_clear_instr;
		logic sleep_instr;
		logic watchdog_expire;
		logic pc_load;
	} core_evt_t;

endpackage

//--- logic/cpu_flags_bank_select_regs.sv
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
// How it works
// - flag-affecting op writing flag reg: zero, digit carry, carry not written; op sets only the flags it affects
// - time-out and power-down bits ignore all software writes
// - bit 7 picks indirect bank pair: 1 upper 100h-1FFh, 0 lower
// - bits 6-5 pick one of four 128-byte direct banks
// - time-out set by power-up, watchdog clear, sleep; cleared on watchdog expiry
// - power-down set by power-up or watchdog clear; cleared by sleep
// - zero flag set when add, subtract or logic result is zero, cleared otherwise
// - digit carry is carry out of bit 3 on add and subtract
// - carry is carry out of bit 7 on add and subtract
// - subtract adds two's complement, so carries mean no borrow, except digit carry is 0 when b is nonzero with low nibble 0
// - rotates load carry with bit shifted out of the source
// - 5-bit pc high holding register copied to pc 12:8 on load
// - mirrored registers reachable at same low offset in every bank
// - unimplemented locations read as zero
// - shared prescaler belongs to watchdog or timer zero, never both
// - prescaler on watchdog gives timer zero a 1:1 rate
// - watchdog period select is the postscale input, registered each cycle
// - config bit 3: 1 prescaler to watchdog, 0 to timer zero
module cpu_flags_bank_select_regs
	import flags_bank_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire bus_req_t i_bus,
	input wire alu_req_t i_alu,
	input wire core_evt_t i_evt,
	input wire logic [7:0] i_indirect_rdata,
	input wire logic [3:0] i_watchdog_postscale,
	output logic [7:0] o_rdata,
	output logic [8:0] o_indirect_addr,
	output logic [1:0] o_direct_bank,
	output logic [7:0] o_alu_result,
	output logic [4:0] o_pc_high,
	output logic o_prescaler_to_watchdog,
	output logic o_timer_zero_unscaled,
	output logic [3:0] o_watchdog_period_sel,
	output logic [7:0] o_port_b_dir
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] flags;
		logic [7:0] prescale_cfg;
		logic [7:0] pc_low;
		logic [7:0] ind_ptr;
		logic [7:0] port_b_dir;
		logic [4:0] pc_high_hold;
		logic [7:0] int_ctrl;
		logic [7:0] nvm_ctrl;
		logic [4:0] pc_high;
		logic [3:0] watchdog_period;
		logic [7:0] alu_res;
		logic [7:0] rdata;
	} state_t;

	state_t st_reg;
	state_t st_next;
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] opb;
	logic arith;
	logic flag_op;
	logic [8:0] ea;
	logic [7:0] rv;

	always_comb begin
		st_next = st_reg;
		sum = 9'h000;
		nib = 5'h00;
		opb = i_alu.b;
		arith = 1'b0;
		flag_op = 1'b0;
		rv = 8'h00;
		if (i_alu.op == OP_SUB) begin
			opb = 8'(~i_alu.b + 8'h01);
		end
		// mirrored low offsets map into bank 3 view
		ea = i_bus.addr;
		case (i_bus.addr[6:0])
			OFS_INDIRECT_DATA[6:0], OFS_PC_LOW[6:0], OFS_FLAGS[6:0],
			OFS_INDIRECT_PTR[6:0], OFS_PC_HIGH_HOLD[6:0], OFS_INT_CONTROL[6:0]: begin
				ea = {2'b11, i_bus.addr[6:0] & MIRROR_MASK};
			end
			default: begin
			end
		endcase
		// ----------------------------------------
		// software writes
		// ----------------------------------------
		if (i_bus.wr) begin
			if (ea == OFS_PRESCALE_CFG) begin
				st_next.prescale_cfg = i_bus.wdata;
			end else if (ea == OFS_PC_LOW) begin
				st_next.pc_low = i_bus.wdata;
			end else if (ea == OFS_FLAGS) begin
				st_next.flags[7:5] = i_bus.wdata[7:5];
				if (i_alu.op == OP_NONE) begin
					st_next.flags[2:0] = i_bus.wdata[2:0];
				end
			end else if (ea == OFS_INDIRECT_PTR) begin
				st_next.ind_ptr = i_bus.wdata;
			end else if (ea == OFS_PORT_B_DIR) begin
				st_next.port_b_dir = i_bus.wdata;
			end else if (ea == OFS_PC_HIGH_HOLD) begin
				st_next.pc_high_hold = i_bus.wdata[PC_HIGH_BITS-1:0];
			end else if (ea == OFS_INT_CONTROL) begin
				st_next.int_ctrl = i_bus.wdata;
			end else if (ea == OFS_NVM_CONTROL) begin
				st_next.nvm_ctrl = i_bus.wdata;
			end
		end
		// ----------------------------------------
		// alu flag update overrides written data
		// ----------------------------------------
		case (i_alu.op)
			OP_ADD, OP_SUB: begin
				sum = {1'b0, i_alu.a} + {1'b0, opb};
				nib = {1'b0, i_alu.a[3:0]} + {1'b0, opb[3:0]};
				if (i_alu.op == OP_SUB && i_alu.b == 8'h00) begin
					sum[8] = 1'b1;
					nib[4] = 1'b1;
				end
				arith = 1'b1;
				flag_op = 1'b1;
				st_next.alu_res = sum[7:0];
				st_next.flags[BIT_DIGIT_CARRY] = nib[4];
				st_next.flags[BIT_CARRY] = sum[8];
				st_next.flags[BIT_ZERO] = (sum[7:0] == 8'h00);
			end
			OP_LOGIC: begin
				flag_op = 1'b1;
				st_next.alu_res = i_alu.a;
				st_next.flags[BIT_ZERO] = (i_alu.a == 8'h00);
			end
			OP_ROT_LEFT: begin
				st_next.alu_res = {i_alu.a[6:0], st_reg.flags[BIT_CARRY]};
				st_next.flags[BIT_CARRY] = i_alu.a[7];
			end
			OP_ROT_RIGHT: begin
				st_next.alu_res = {st_reg.flags[BIT_CARRY], i_alu.a[7:1]};
				st_next.flags[BIT_CARRY] = i_alu.a[0];
			end
			default: begin
			end
		endcase
		// ----------------------------------------
		// time-out and power-down from core events
		// ----------------------------------------
		if (i_evt.watchdog_expire) begin
			st_next.flags[BIT_TIMEOUT] = 1'b0;
		end else if (i_evt.watchdog_clear_instr || i_evt.sleep_instr) begin
			st_next.flags[BIT_TIMEOUT] = 1'b1;
		end
		if (i_evt.sleep_instr) begin
			st_next.flags[BIT_POWERDOWN] = 1'b0;
		end else if (i_evt.watchdog_clear_instr) begin
			st_next.flags[BIT_POWERDOWN] = 1'b1;
		end
		if (i_evt.pc_load) begin
			st_next.pc_high = st_reg.pc_high_hold;
		end
		st_next.watchdog_period = i_watchdog_postscale;
		// ----------------------------------------
		// read mux, data one cycle later
		// ----------------------------------------
		if (ea == OFS_INDIRECT_DATA) begin
			rv = i_indirect_rdata;
		end else if (ea == OFS_PRESCALE_CFG) begin
			rv = st_reg.prescale_cfg;
		end else if (ea == OFS_PC_LOW) begin
			rv = st_reg.pc_low;
		end else if (ea == OFS_FLAGS) begin
			rv = st_reg.flags;
		end else if (ea == OFS_INDIRECT_PTR) begin
			rv = st_reg.ind_ptr;
		end else if (ea == OFS_PORT_B_DIR) begin
			rv = st_reg.port_b_dir;
		end else if (ea == OFS_PC_HIGH_HOLD) begin
			rv = {3'b000, st_reg.pc_high_hold};
		end else if (ea == OFS_INT_CONTROL) begin
			rv = st_reg.int_ctrl;
		end else if (ea == OFS_NVM_CONTROL) begin
			rv = st_reg.nvm_ctrl;
		end else if (ea == OFS_NVM_UNLOCK) begin
			rv = 8'h00;
		end else begin
			rv = 8'h00;
		end
		st_next.rdata = i_bus.rd ? rv : 8'h00;
		if (i_sys_rst) begin
			st_next = '0;
			st_next.flags = RST_FLAGS;
			st_next.prescale_cfg = RST_PRESCALE_CFG;
			st_next.port_b_dir = RST_PORT_B_DIR;
			st_next.watchdog_period = RST_WATCHDOG_POSTSCALE;
		end
	end

	always_ff @(posedge i_clk) begin
		st_reg <= st_next;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign o_rdata = st_reg.rdata;
	assign o_indirect_addr = {st_reg.flags[BIT_IND_BANK], st_reg.ind_ptr};
	assign o_direct_bank = st_reg.flags[BIT_DIR_BANK_HI:BIT_DIR_BANK_LO];
	assign o_alu_result = st_reg.alu_res;
	assign o_pc_high = st_reg.pc_high;
	assign o_prescaler_to_watchdog = st_reg.prescale_cfg[BIT_PRESCALER_ASSIGN];
	assign o_timer_zero_unscaled = st_reg.prescale_cfg[BIT_PRESCALER_ASSIGN];
	assign o_watchdog_period_sel = st_reg.watchdog_period;
	assign o_port_b_dir = st_reg.port_b_dir;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	a_sw_no_td: assert property (i_bus.wr && !i_evt.sleep_instr && !i_evt.watchdog_clear_instr
		&& !i_evt.watchdog_expire |=> $stable(st_reg.flags[4:3])) else $error("td written");
	a_sleep_bits: assert property (i_evt.sleep_instr && !i_evt.watchdog_expire |=>
		st_reg.flags[4:3] == 2'b10) else $error("sleep flags wrong");
	a_clr_bits: assert property (i_evt.watchdog_clear_instr && !i_evt.sleep_instr
		&& !i_evt.watchdog_expire |=> st_reg.flags[4:3] == 2'b11) else $error("clr flags");
	a_zero_flag: assert property (i_alu.op == OP_LOGIC |=>
		st_reg.flags[2] == (st_reg.alu_res == 8'h00)) else $error("zero flag");
	a_add_carry: assert property (i_alu.op == OP_ADD |=>
		st_reg.flags[0] == $past({1'b0, i_alu.a} + {1'b0, i_alu.b}, 1) >> 8)
		else $error("carry wrong");
	a_rot_left: assert property (i_alu.op == OP_ROT_LEFT |=>
		st_reg.flags[0] == $past(i_alu.a[7])) else $error("rotate carry");
	a_pc_load: assert property (i_evt.pc_load |=> o_pc_high == $past(st_reg.pc_high_hold))
		else $error("pc high load");
	a_unlock_zero: assert property (i_bus.rd && i_bus.addr == OFS_NVM_UNLOCK |=>
		o_rdata == 8'h00) else $error("unlock reads data");
	a_mirror_read: assert property (i_bus.rd && i_bus.addr == 9'h003 |=>
		o_rdata == $past(st_reg.flags)) else $error("mirror read");
	a_unimpl_zero: assert property (i_bus.rd && i_bus.addr == 9'h185 |=> o_rdata == 8'h00)
		else $error("unimpl nonzero");

	c_sub_op: cover property (i_alu.op == OP_SUB);
	c_sleep: cover property (i_evt.sleep_instr);
	c_flag_write: cover property (i_bus.wr && i_bus.addr == OFS_FLAGS && flag_op);
	c_expire: cover property (i_evt.watchdog_expire ##1 i_evt.watchdog_clear_instr);

	// ----------------------------------------
	// flag register write checks
	// ----------------------------------------
	a_wr_ind_bank: assert property (i_bus.wr && i_bus.addr[6:0] == OFS_FLAGS[6:0]
		|=> o_indirect_addr[8] == $past(i_bus.wdata[7]))
		else $error("indirect bank not written");

	a_wr_dir_bank: assert property (i_bus.wr && i_bus.addr[6:0] == OFS_FLAGS[6:0]
		|=> o_direct_bank == $past(i_bus.wdata[6:5]))
		else $error("direct bank not written");

	a_wr_low_bits: assert property (i_bus.wr && i_bus.addr[6:0] == OFS_FLAGS[6:0]
		&& i_alu.op == OP_NONE |=> st_reg.flags[2:0] == $past(i_bus.wdata[2:0]))
		else $error("arith flags not written");

	a_op_keeps_carry: assert property (i_bus.wr && i_bus.addr[6:0] == OFS_FLAGS[6:0]
		&& i_alu.op == OP_LOGIC |=> st_reg.flags[1:0] == $past(st_reg.flags[1:0]))
		else $error("write reached carry bits");

	// ----------------------------------------
	// time-out and power-down checks
	// ----------------------------------------
	a_expire_clears: assert property (i_evt.watchdog_expire
		|=> !st_reg.flags[BIT_TIMEOUT])
		else $error("expiry left time-out set");

	a_pd_stable: assert property (!i_evt.sleep_instr && !i_evt.watchdog_clear_instr
		|=> $stable(st_reg.flags[BIT_POWERDOWN]))
		else $error("power-down moved");

	a_to_stable: assert property (!i_evt.sleep_instr && !i_evt.watchdog_clear_instr
		&& !i_evt.watchdog_expire |=> $stable(st_reg.flags[BIT_TIMEOUT]))
		else $error("time-out moved");

	// ----------------------------------------
	// alu flag and result checks
	// ----------------------------------------
	a_add_digit: assert property (i_alu.op == OP_ADD
		|=> st_reg.flags[1] == $past({1'b0, i_alu.a[3:0]} + {1'b0, i_alu.b[3:0]}) >> 4)
		else $error("digit carry wrong");

	a_add_result: assert property (i_alu.op == OP_ADD
		|=> st_reg.alu_res == 8'($past(i_alu.a) + $past(i_alu.b)))
		else $error("add result wrong");

	a_add_zero: assert property (i_alu.op == OP_ADD
		|=> st_reg.flags[BIT_ZERO] == (st_reg.alu_res == 8'h00))
		else $error("add zero flag");

	a_logic_nonzero: assert property (i_alu.op == OP_LOGIC && i_alu.a != 8'h00
		|=> !st_reg.flags[BIT_ZERO])
		else $error("zero flag on nonzero");

	a_sub_carry: assert property (i_alu.op == OP_SUB
		|=> st_reg.flags[0] == ($past(i_alu.a) >= $past(i_alu.b)))
		else $error("borrow wrong");

	a_sub_digit: assert property (i_alu.op == OP_SUB
		|=> st_reg.flags[1] == ($past(i_alu.a[3:0]) >= $past(i_alu.b[3:0])))
		else $error("digit borrow wrong");

	a_sub_result: assert property (i_alu.op == OP_SUB
		|=> st_reg.alu_res == 8'($past(i_alu.a) - $past(i_alu.b)))
		else $error("sub result wrong");

	a_rot_right: assert property (i_alu.op == OP_ROT_RIGHT
		|=> st_reg.flags[0] == $past(i_alu.a[0]))
		else $error("rotate right carry");

	a_rot_fill: assert property (i_alu.op == OP_ROT_LEFT
		|=> st_reg.alu_res[0] == $past(st_reg.flags[0]))
		else $error("rotate fill bit");

	// ----------------------------------------
	// pointer and map checks
	// ----------------------------------------
	a_ptr_route: assert property (i_bus.wr && i_bus.addr[6:0] == OFS_INDIRECT_PTR[6:0]
		|=> o_indirect_addr[7:0] == $past(i_bus.wdata))
		else $error("pointer mirror write");

	a_ind_data: assert property (i_bus.rd && i_bus.addr[6:0] == OFS_INDIRECT_DATA[6:0]
		|=> o_rdata == $past(i_indirect_rdata))
		else $error("indirect data read");

	a_pch_upper: assert property (i_bus.rd && i_bus.addr[6:0] == OFS_PC_HIGH_HOLD[6:0]
		|=> o_rdata[7:5] == 3'b000)
		else $error("holding upper bits");

	a_pch_no_direct: assert property (i_bus.wr && i_bus.addr[6:0] == OFS_PC_HIGH_HOLD[6:0]
		&& !i_evt.pc_load |=> $stable(o_pc_high))
		else $error("pc high written directly");

	a_rsvd_zero: assert property (i_bus.rd && i_bus.addr == OFS_RSVD_A
		|=> o_rdata == 8'h00)
		else $error("reserved nonzero");

	// ----------------------------------------
	// prescaler and watchdog checks
	// ----------------------------------------
	a_psa_route: assert property (i_bus.wr && i_bus.addr == OFS_PRESCALE_CFG
		|=> o_prescaler_to_watchdog == $past(i_bus.wdata[BIT_PRESCALER_ASSIGN]))
		else $error("prescaler route");

	a_timer_unscaled: assert property (o_timer_zero_unscaled == o_prescaler_to_watchdog)
		else $error("timer rate");

	a_period_follow: assert property (!i_sys_rst
		|=> o_watchdog_period_sel == $past(i_watchdog_postscale))
		else $error("watchdog period");

	c_logic_flag_wr: cover property (i_bus.wr && i_bus.addr[6:0] == 7'h03 && i_alu.op == OP_LOGIC);

endmodule // cpu_flags_bank_select_regs

//--- test/cpu_flags_bank_select_regs_tb_top.sv
`timescale 1ns/1ns
module cpu_flags_bank_select_regs_tb_top;
	import flags_bank_pkg::*;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	bus_req_t i_bus = '0;
	alu_req_t i_alu = '0;
	core_evt_t i_evt = '0;
	logic [7:0] i_indirect_rdata = 8'hc3;
	logic [3:0] i_watchdog_postscale = 4'h8;
	logic [7:0] o_rdata, o_alu_result, o_port_b_dir;
	logic [8:0] o_indirect_addr;
	logic [1:0] o_direct_bank;
	logic [4:0] o_pc_high;
	logic o_prescaler_to_watchdog, o_timer_zero_unscaled;
	logic [3:0] o_watchdog_period_sel;
	int err_total = 0;
	int total_checks = 0;
	cpu_flags_bank_select_regs i_cpu_flags_bank_select_regs (.i_clk(i_clk),
		.i_sys_rst(i_sys_rst), .i_bus(i_bus), .i_alu(i_alu), .i_evt(i_evt),
		.i_indirect_rdata(i_indirect_rdata), .i_watchdog_postscale(i_watchdog_postscale),
		.o_rdata(o_rdata), .o_indirect_addr(o_indirect_addr), .o_direct_bank(o_direct_bank),
		.o_alu_result(o_alu_result), .o_pc_high(o_pc_high),
		.o_prescaler_to_watchdog(o_prescaler_to_watchdog),
		.o_timer_zero_unscaled(o_timer_zero_unscaled),
		.o_watchdog_period_sel(o_watchdog_period_sel), .o_port_b_dir(o_port_b_dir));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [8:0] got, input logic [8:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_clk);
		i_bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [8:0] a, output logic [7:0] d);
		@(posedge i_clk);
		i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge i_clk);
		i_bus.rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	task automatic rdchk(input logic [8:0] a, input logic [7:0] e, input string n);
		logic [7:0] d;
		rd(a, d);
		chk(n, 9'(d), 9'(e));
	endtask
	task automatic settle;
		@(posedge i_clk);
		#1;
	endtask
	task automatic alu_chk(input alu_op_t op, input logic [7:0] a, b, res, input logic [2:0] zdc);
		logic [7:0] d;
		@(posedge i_clk);
		i_alu <= '{op: op, a: a, b: b};
		@(posedge i_clk);
		i_alu.op <= OP_NONE;
		#1 chk("alu_result", 9'(o_alu_result), 9'(res));
		rd(OFS_FLAGS, d);
		chk("flags_zdc", 9'(d[2:0]), 9'(zdc));
	endtask
	task automatic evt(input core_evt_t e, input logic [1:0] exp);
		logic [7:0] d;
		@(posedge i_clk);
		i_evt <= e;
		@(posedge i_clk);
		i_evt <= '0;
		rd(OFS_FLAGS, d);
		chk("timeout_powerdown", 9'(d[4:3]), 9'(exp));
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		rdchk(OFS_FLAGS, RST_FLAGS, "flags_rst");
		rdchk(OFS_PRESCALE_CFG, 8'hff, "cfg_rst");
		rdchk(OFS_PORT_B_DIR, 8'hff, "portb_rst");
		rdchk(OFS_PC_HIGH_HOLD, 8'h00, "pch_rst");
		chk("pc_high_rst", 9'(o_pc_high), 9'h000);
		chk("watchdog_sel_rst", 9'(o_watchdog_period_sel), 9'h008);
		settle();
		chk("rdata_stands", 9'(o_rdata), 9'h000);
	endtask
	task automatic t_flags;
		wr(9'h003, 8'h00);
		rdchk(OFS_FLAGS, 8'h18, "flags_wr0");
		wr(9'h103, 8'he7);
		rdchk(OFS_FLAGS, 8'hff, "flags_wr_ff");
		@(posedge i_clk);
		i_alu <= '{op: OP_ADD, a: 8'hff, b: 8'h01};
		i_bus <= '{addr: 9'h003, wdata: 8'h60, wr: 1'b1, rd: 1'b0};
		@(posedge i_clk);
		i_alu.op <= OP_NONE;
		i_bus.wr <= 1'b0;
		rdchk(OFS_FLAGS, 8'h7f, "flags_alu_vs_wr");
		@(posedge i_clk);
		i_alu <= '{op: OP_LOGIC, a: 8'h05, b: 8'h00};
		i_bus <= '{addr: 9'h183, wdata: 8'h00, wr: 1'b1, rd: 1'b0};
		@(posedge i_clk);
		i_alu.op <= OP_NONE;
		i_bus.wr <= 1'b0;
		rdchk(OFS_FLAGS, 8'h1b, "flags_logic_vs_wr");
	endtask
	task automatic t_banks;
		wr(9'h104, 8'h5a);
		for (int i = 0; i < 4; i++) begin
			wr(9'h083, {1'b1, 2'(i), 5'h00});
			settle();
			chk("direct_bank", 9'(o_direct_bank), 9'(i));
			chk("ind_addr_hi", o_indirect_addr, 9'h15a);
		end
		wr(9'h183, 8'h00);
		settle();
		chk("ind_addr_lo", o_indirect_addr, 9'h05a);
		rdchk(9'h084, 8'h5a, "ptr_mirror1");
		rdchk(9'h004, 8'h5a, "ptr_mirror0");
		rdchk(9'h100, 8'hc3, "ind_data_port");
	endtask
	task automatic t_alu;
		alu_chk(OP_ADD, 8'h0f, 8'h01, 8'h10, 3'b010);
		alu_chk(OP_ADD, 8'hff, 8'h01, 8'h00, 3'b111);
		alu_chk(OP_SUB, 8'h05, 8'h05, 8'h00, 3'b111);
		alu_chk(OP_SUB, 8'h00, 8'h01, 8'hff, 3'b000);
		alu_chk(OP_LOGIC, 8'h00, 8'h00, 8'h00, 3'b100);
		alu_chk(OP_ROT_LEFT, 8'h80, 8'h00, 8'h00, 3'b101);
		alu_chk(OP_ROT_RIGHT, 8'h02, 8'h00, 8'h81, 3'b100);
		alu_chk(OP_SUB, 8'h10, 8'h01, 8'h0f, 3'b001);
	endtask
	task automatic t_events;
		evt(4'b0100, 2'b10);
		evt(4'b0010, 2'b00);
		evt(4'b1000, 2'b11);
		evt(4'b1010, 2'b01);
		evt(4'b1100, 2'b10);
		evt(4'b1000, 2'b11);
	endtask
	task automatic t_pc_high;
		wr(OFS_PC_HIGH_HOLD, 8'hff);
		rdchk(9'h10a, 8'h1f, "pch_rd");
		chk("pc_high_hold", 9'(o_pc_high), 9'h000);
		evt(4'b0001, 2'b11);
		chk("pc_high_load", 9'(o_pc_high), 9'h01f);
		wr(9'h00a, 8'h2a);
		evt(4'b0001, 2'b11);
		chk("pc_high_load2", 9'(o_pc_high), 9'h00a);
	endtask
	task automatic t_unimpl;
		logic [8:0] holes[7] = '{9'h185, 9'h187, 9'h188, 9'h189, 9'h18d, 9'h18e, 9'h18f};
		foreach (holes[i]) begin
			wr(holes[i], (holes[i] >= OFS_RSVD_A) ? 8'h00 : 8'hff);
			rdchk(holes[i], 8'h00, "unimpl_rd");
		end
	endtask
	task automatic t_prescale;
		wr(OFS_PRESCALE_CFG, 8'hf7);
		settle();
		chk("prescaler_to_watchdog0", 9'(o_prescaler_to_watchdog), 9'h000);
		chk("timer_zero_unscaled0", 9'(o_timer_zero_unscaled), 9'h000);
		rdchk(OFS_PRESCALE_CFG, 8'hf7, "cfg_rd");
		wr(OFS_PRESCALE_CFG, 8'hff);
		settle();
		chk("prescaler_to_watchdog1", 9'(o_prescaler_to_watchdog), 9'h001);
		chk("timer_zero_unscaled1", 9'(o_timer_zero_unscaled), 9'h001);
		@(posedge i_clk);
		i_watchdog_postscale <= 4'h3;
		settle();
		settle();
		chk("watchdog_sel", 9'(o_watchdog_period_sel), 9'h003);
		wr(OFS_PORT_B_DIR, 8'h5a);
		settle();
		chk("portb_dir", 9'(o_port_b_dir), 9'h05a);
	endtask
	// ----------------------------------------
	// run control
	// ----------------------------------------
	initial begin
		forever #20 i_clk = ~i_clk;
	end
	initial begin
		repeat (16) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		t_reset();
		t_flags();
		t_banks();
		t_alu();
		t_events();
		t_pc_high();
		t_unimpl();
		t_prescale();
		end_sim();
	end
	initial begin
		#200000;
		err_total++;
		end_sim();
	end
endmodule // cpu_flags_bank_select_regs_tb_top
